//--- design/rsu_map.vh
// constants for the receive signaling unit
`ifndef RSU_MAP_VH
`define RSU_MAP_VH

// framing modes on mode_sel
`define RSU_MODE_ESF      2'h0
`define RSU_MODE_D4       2'h1
`define RSU_MODE_E1       2'h2

// frames per multiframe, counted 0 to n-1
`define RSU_FRAMES_ESF    5'h18
`define RSU_FRAMES_D4     5'h0C
`define RSU_FRAMES_E1     5'h10

// last bit position of a backplane frame
`define RSU_LAST_POS_1544 8'hC0
`define RSU_LAST_POS_2048 8'hFF

// channel layout
`define RSU_T1_CHANNELS   5'h18
`define RSU_E1_SIG_TS     5'h10
`define RSU_ROBBED_BIT    3'h7
`define RSU_RD_OFFSET     2'h1

// integration depth in multiframes, less one
`define RSU_INTEG_LAST    2'h2

// freeze hold-off times in microseconds and the clock rate in MHz
`define RSU_HOLD_ESF_US   9000
`define RSU_HOLD_D4_US    4500
`define RSU_HOLD_E1_US    6000
`define RSU_CLK_MHZ       20

`endif

//--- design/rsu_rx_signaling_unit.v
// receive signaling extraction, change detection, freeze and reinsertion
`timescale 1ns/100ps
`default_nettype none
`include "rsu_map.vh"

module rsu_rx_signaling_unit #(
   parameter [17:0] HOLD_ESF_CYC = `RSU_HOLD_ESF_US * `RSU_CLK_MHZ,
   parameter [17:0] HOLD_D4_CYC  = `RSU_HOLD_D4_US * `RSU_CLK_MHZ,
   parameter [17:0] HOLD_E1_CYC  = `RSU_HOLD_E1_US * `RSU_CLK_MHZ
) (
   input  wire         clk_sys,
   input  wire         rst_b,
   input  wire [1:0]   mode_sel,
   input  wire         integration_enable,
   input  wire [31:0]  change_state_enable_bits,
   input  wire [31:0]  change_flags_clear,
   input  wire         latched_status_clear,
   input  wire         rx_interrupt_mask_four,
   input  wire         freeze_enable,
   input  wire         freeze_force,
   input  wire [31:0]  reinsertion_enable_bits,
   input  wire [23:0]  force_ones_select_bits,
   input  wire         elastic_store_enable,
   input  wire         backplane_rate_2048,
   input  wire         sig_valid,
   input  wire [4:0]   sig_channel,
   input  wire [3:0]   sig_abcd,
   input  wire         multiframe_boundary,
   input  wire         out_of_frame,
   input  wire         loss_of_frame,
   input  wire         carrier_loss,
   input  wire         alignment_change,
   input  wire         rx_backplane_clock,
   input  wire         rx_multiframe_sync,
   input  wire         rx_serial_data_in,
   output reg  [127:0] rx_signaling_regs,
   output reg  [31:0]  rx_signaling_change_flags,
   output reg          rx_latched_status_four,
   output reg          interrupt_out_n,
   output reg          freeze_indicator_out,
   output reg          rx_signaling_stream_out,
   output reg          rx_serial_data_out
);

   reg          rst_s1_reg;
   reg          rst_n;
   reg          bpc_s1_reg;
   reg          bpc_s2_reg;
   reg          bpc_s3_reg;
   reg          mfs_s1_reg;
   reg          mfs_s2_reg;
   reg          mfs_s3_reg;
   reg  [127:0] stage_reg;
   reg  [127:0] buf_mem [0:3];
   reg  [1:0]   wp_reg;
   reg  [127:0] cand_reg;
   reg  [63:0]  cnt_reg;
   reg  [127:0] regs_next;
   reg  [127:0] cand_next;
   reg  [63:0]  cnt_next;
   reg  [31:0]  accept;
   reg  [3:0]   nv;
   reg  [17:0]  hold_reg;
   reg  [7:0]   pos_reg;
   reg  [4:0]   frame_reg;
   reg          stream_bit;
   reg          serial_bit;
   reg  [7:0]   s_byte;
   reg  [3:0]   r_abcd;
   reg  [4:0]   e1_ts;
   reg  [2:0]   slot;
   integer      i;

   wire         is_e1      = (mode_sel == `RSU_MODE_E1);
   wire         sync_loss  = out_of_frame | loss_of_frame;
   wire         line_fault = sync_loss | carrier_loss | alignment_change;
   wire         freeze_now = freeze_force |
                             (freeze_enable & (line_fault |
                                               (hold_reg != 18'h00000)));
   wire         take_mf    = multiframe_boundary & ~sync_loss;
   wire [31:0]  change_set = take_mf ? accept : 32'h00000000;
   wire         bp_edge    = bpc_s2_reg & ~bpc_s3_reg;
   wire         sync_rise  = mfs_s2_reg & ~mfs_s3_reg;
   wire [1:0]   rd_idx     = wp_reg + `RSU_RD_OFFSET;
   wire [127:0] rd_word    = buf_mem[rd_idx];
   wire [31:0]  force_ext  = {8'h00, force_ones_select_bits};
   wire         f_bit      = ~backplane_rate_2048 & (pos_reg == 8'h00);
   wire [7:0]   pos_adj    = backplane_rate_2048 ? pos_reg :
                             pos_reg - 8'h01;
   wire [4:0]   ch         = pos_adj[7:3];
   wire [2:0]   bit_no     = pos_adj[2:0];
   wire [7:0]   last_pos   = backplane_rate_2048 ? `RSU_LAST_POS_2048 :
                             `RSU_LAST_POS_1544;
   wire         reins_ok   = elastic_store_enable &
                             (~is_e1 | backplane_rate_2048);

   // hold-off length after a fault, per framing mode
   function [17:0] hold_len;
      input [1:0] mode;
      begin
         case (mode)
            `RSU_MODE_D4: hold_len = HOLD_D4_CYC;
            `RSU_MODE_E1: hold_len = HOLD_E1_CYC;
            default:      hold_len = HOLD_ESF_CYC;
         endcase
      end
   endfunction

   function [4:0] frames_per_mf;
      input [1:0] mode;
      begin
         case (mode)
            `RSU_MODE_D4: frames_per_mf = `RSU_FRAMES_D4;
            `RSU_MODE_E1: frames_per_mf = `RSU_FRAMES_E1;
            default:      frames_per_mf = `RSU_FRAMES_ESF;
         endcase
      end
   endfunction

   // buffered signaling of one channel, after all-ones forcing
   function [3:0] abcd_of;
      input [4:0]   idx;
      input [127:0] word;
      input [31:0]  frc;
      input         e1;
      begin
         if (~e1 & frc[idx])
            abcd_of = 4'hF;
         else
            abcd_of = word[{idx, 2'b00} +: 4];
      end
   endfunction

   // signaling byte on the stream: low nibble carries the bits
   function [7:0] stream_byte;
      input [1:0] mode;
      input [3:0] abcd;
      begin
         if (mode == `RSU_MODE_D4)
            stream_byte = {4'h0, abcd[3:2], abcd[3:2]};
         else
            stream_byte = {4'h0, abcd};
      end
   endfunction

   // robbed-bit frames of a T1 multiframe: hit flag and letter index
   function [2:0] robbed_slot;
      input [4:0] fr;
      begin
         case (fr)
            5'h05:   robbed_slot = 3'h4;
            5'h0B:   robbed_slot = 3'h5;
            5'h11:   robbed_slot = 3'h6;
            5'h17:   robbed_slot = 3'h7;
            default: robbed_slot = 3'h0;
         endcase
      end
   endfunction

   // reset release through two flops
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // backplane pins are asynchronous to clk_sys
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bpc_s1_reg <= 1'b0;
         bpc_s2_reg <= 1'b0;
         bpc_s3_reg <= 1'b0;
         mfs_s1_reg <= 1'b0;
         mfs_s2_reg <= 1'b0;
         mfs_s3_reg <= 1'b0;
      end else begin
         bpc_s1_reg <= rx_backplane_clock;
         bpc_s2_reg <= bpc_s1_reg;
         bpc_s3_reg <= bpc_s2_reg;
         mfs_s1_reg <= rx_multiframe_sync;
         mfs_s2_reg <= mfs_s1_reg;
         mfs_s3_reg <= mfs_s2_reg;
      end
   end

   // per-channel acceptance of a new signaling value
   always @* begin
      regs_next = rx_signaling_regs;
      cand_next = cand_reg;
      cnt_next  = cnt_reg;
      accept    = 32'h00000000;
      nv        = 4'h0;
      for (i = 0; i < 32; i = i + 1) begin
         nv = stage_reg[i*4 +: 4];
         if (nv == rx_signaling_regs[i*4 +: 4]) begin
            cnt_next[i*2 +: 2] = 2'h0;
         end else if (!integration_enable) begin
            accept[i] = 1'b1;
         end else if (nv == cand_reg[i*4 +: 4]) begin
            if (cnt_reg[i*2 +: 2] == `RSU_INTEG_LAST)
               accept[i] = 1'b1;
            else
               cnt_next[i*2 +: 2] = cnt_reg[i*2 +: 2] + 2'h1;
         end else begin
            cand_next[i*4 +: 4] = nv;
            cnt_next[i*2 +: 2]  = 2'h1;
         end
         if (accept[i]) begin
            regs_next[i*4 +: 4] = nv;
            cnt_next[i*2 +: 2]  = 2'h0;
         end
      end
   end

   // line side: capture, host copy, change flags, buffer, freeze
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage_reg                 <= 128'h0;
         cand_reg                  <= 128'h0;
         cnt_reg                   <= 64'h0;
         rx_signaling_regs         <= 128'h0;
         rx_signaling_change_flags <= 32'h00000000;
         rx_latched_status_four    <= 1'b0;
         interrupt_out_n           <= 1'b1;
         buf_mem[0]                <= 128'h0;
         buf_mem[1]                <= 128'h0;
         buf_mem[2]                <= 128'h0;
         buf_mem[3]                <= 128'h0;
         wp_reg                    <= 2'h0;
         hold_reg                  <= 18'h00000;
         freeze_indicator_out      <= 1'b0;
      end else begin
         if (sig_valid)
            stage_reg[{sig_channel, 2'b00} +: 4] <= sig_abcd;
         // host copy waits for a multiframe and skips sync loss
         if (take_mf) begin
            rx_signaling_regs <= regs_next;
            cand_reg          <= cand_next;
            cnt_reg           <= cnt_next;
         end
         // set wins over a clear in the same cycle
         rx_signaling_change_flags <= (rx_signaling_change_flags &
                                       ~change_flags_clear) |
                                      change_set;
         rx_latched_status_four <= (rx_latched_status_four &
                                    ~latched_status_clear) |
                                   (|(change_set &
                                      change_state_enable_bits));
         interrupt_out_n <= ~(rx_latched_status_four &
                              rx_interrupt_mask_four);
         // the buffer keeps filling while the host copy is read
         if (multiframe_boundary && !freeze_now) begin
            buf_mem[wp_reg] <= stage_reg;
            wp_reg          <= wp_reg + 2'h1;
         end
         if (line_fault)
            hold_reg <= hold_len(mode_sel);
         else if (hold_reg != 18'h00000)
            hold_reg <= hold_reg - 18'h00001;
         freeze_indicator_out <= freeze_now;
      end
   end

   // bit that leaves on the next backplane edge
   always @* begin
      stream_bit = 1'b0;
      serial_bit = rx_serial_data_in;
      e1_ts      = frame_reg;
      slot       = robbed_slot(frame_reg);
      r_abcd     = 4'h0;
      // a function result cannot be bit-selected, so hold it first
      s_byte     = stream_byte(mode_sel,
                               abcd_of(ch, rd_word, force_ext, is_e1));
      if (!f_bit && (is_e1 || ch < `RSU_T1_CHANNELS))
         stream_bit = s_byte[3'h7 - bit_no];
      if (!is_e1) begin
         if (!f_bit && ch < `RSU_T1_CHANNELS &&
             bit_no == `RSU_ROBBED_BIT && slot[2]) begin
            if (force_ext[ch])
               serial_bit = 1'b1;
            else if (reins_ok && reinsertion_enable_bits[ch]) begin
               r_abcd     = abcd_of(ch, rd_word, force_ext, 1'b0);
               serial_bit = r_abcd[2'h3 - slot[1:0]];
            end
         end
      end else if (ch == `RSU_E1_SIG_TS && frame_reg != 5'h00) begin
         // time slot 16 of frame n carries slots n and n+16
         e1_ts = bit_no[2] ? frame_reg + `RSU_E1_SIG_TS : frame_reg;
         if (reins_ok && reinsertion_enable_bits[e1_ts]) begin
            r_abcd     = abcd_of(e1_ts, rd_word, force_ext, 1'b1);
            serial_bit = r_abcd[2'h3 - bit_no[1:0]];
         end
      end
   end

   // backplane side: either clock rate, position from external sync
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pos_reg                 <= 8'h00;
         frame_reg               <= 5'h00;
         rx_signaling_stream_out <= 1'b0;
         rx_serial_data_out      <= 1'b0;
      end else if (sync_rise) begin
         pos_reg   <= 8'h00;
         frame_reg <= 5'h00;
      end else if (bp_edge) begin
         rx_signaling_stream_out <= stream_bit;
         rx_serial_data_out      <= serial_bit;
         if (pos_reg == last_pos) begin
            pos_reg <= 8'h00;
            if (frame_reg == frames_per_mf(mode_sel) - 5'h01)
               frame_reg <= 5'h00;
            else
               frame_reg <= frame_reg + 5'h01;
         end else begin
            pos_reg <= pos_reg + 8'h01;
         end
      end
   end

endmodule
`default_nettype wire

//--- verif/rsu_rx_sig_monitor.sv
// port checker for the receive signaling unit
`timescale 1ns/100ps
`default_nettype none
module rsu_rx_sig_monitor (
   input wire logic         clk_sys,
   input wire logic         rst_b,
   input wire logic [31:0]  change_flags_clear,
   input wire logic         latched_status_clear,
   input wire logic         rx_interrupt_mask_four,
   input wire logic         freeze_enable,
   input wire logic         freeze_force,
   input wire logic         multiframe_boundary,
   input wire logic         loss_of_frame,
   input wire logic         carrier_loss,
   input wire logic         alignment_change,
   input wire logic [127:0] rx_signaling_regs,
   input wire logic [31:0]  rx_signaling_change_flags,
   input wire logic         rx_latched_status_four,
   input wire logic         interrupt_out_n,
   input wire logic         freeze_indicator_out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire logic fault = loss_of_frame | carrier_loss | alignment_change;
   wire logic [31:0] fl = rx_signaling_change_flags;
   property p_flag; ~|($past(fl) & ~fl & ~$past(change_flags_clear)); endproperty
   a_flag: assert property (p_flag) else $error("flag lost");
   property p_lat; $fell(rx_latched_status_four) |-> $past(latched_status_clear);
   endproperty
   a_lat: assert property (p_lat) else $error("latched lost");
   property p_msk; !rx_interrupt_mask_four && !$past(rx_interrupt_mask_four)
      |-> interrupt_out_n; endproperty
   a_msk: assert property (p_msk) else $error("masked irq");
   property p_frc; freeze_force && $past(freeze_force) |-> freeze_indicator_out;
   endproperty
   a_frc: assert property (p_frc) else $error("no forced freeze");
   property p_flt; freeze_enable && fault && $past(freeze_enable && fault)
      |-> freeze_indicator_out; endproperty
   a_flt: assert property (p_flt) else $error("no fault freeze");
   property p_hld; freeze_enable && !freeze_force && $fell(fault)
      |-> freeze_indicator_out[*8]; endproperty
   a_hld: assert property (p_hld) else $error("hold too short");
   property p_mf; !$stable(rx_signaling_regs)
      |-> $past(multiframe_boundary) || $past(multiframe_boundary, 2); endproperty
   a_mf: assert property (p_mf) else $error("regs off boundary");
   property p_lof; loss_of_frame && $past(loss_of_frame)
      && $past(loss_of_frame, 2) |-> $stable(rx_signaling_regs); endproperty
   a_lof: assert property (p_lof) else $error("regs moved in loss");
   c_irq: cover property (!interrupt_out_n);
   c_hld: cover property (freeze_enable && $fell(fault));
   c_lof: cover property (loss_of_frame && multiframe_boundary);
endmodule
bind rsu_rx_signaling_unit rsu_rx_sig_monitor i_rsu_rx_sig_monitor (
   .clk_sys, .rst_b, .change_flags_clear, .latched_status_clear,
   .rx_interrupt_mask_four, .freeze_enable, .freeze_force,
   .multiframe_boundary, .loss_of_frame, .carrier_loss, .alignment_change,
   .rx_signaling_regs, .rx_signaling_change_flags, .rx_latched_status_four,
   .interrupt_out_n, .freeze_indicator_out
);
`default_nettype wire

//--- verif/rsu_backplane_model.sv
// backplane partner: free clock, multiframe sync and serial data
`timescale 1ns/100ps
`default_nettype none
module rsu_backplane_model (
   input  wire logic rate_2048,
   output var logic  bp_clk,
   output var logic  mf_sync,
   output var logic  ser_data
);
   int pos = 0;
   initial begin
      bp_clk = 1'b0;
      mf_sync = 1'b0;
      ser_data = 1'b1;
   end
   // clock runs free; the rate only changes the frame length
   always #200 bp_clk = ~bp_clk;
   // data moves on the falling edge so it is settled at each rise
   always @(negedge bp_clk) begin
      pos <= (pos >= (rate_2048 ? 6143 : 4631)) ? 0 : pos + 1;
      mf_sync <= (pos == 0);
      ser_data <= ser_data ^ pos[0] ^ pos[3];
   end
endmodule
`default_nettype wire

//--- verif/rsu_rx_signaling_unit_tb_top.sv
// self-checking bench for the receive signaling unit
`timescale 1ns/100ps
`default_nettype none
module rsu_rx_signaling_unit_tb_top;
   logic clk_sys = 1'b0, rst_b = 1'b0, integration_enable = 1'b0;
   logic latched_status_clear = 1'b0, rx_interrupt_mask_four = 1'b0;
   logic freeze_enable = 1'b0, freeze_force = 1'b0, sig_valid = 1'b0;
   logic elastic_store_enable = 1'b1, backplane_rate_2048 = 1'b0;
   logic multiframe_boundary = 1'b0, out_of_frame = 1'b0;
   logic loss_of_frame = 1'b0, carrier_loss = 1'b0, alignment_change = 1'b0;
   logic [1:0]   mode_sel = 2'h0;
   logic [4:0]   sig_channel = 5'h0;
   logic [3:0]   sig_abcd = 4'h0;
   logic [23:0]  force_ones_select_bits = 24'h0;
   logic [31:0]  change_state_enable_bits = 32'h0, change_flags_clear = 32'h0;
   logic [31:0]  reinsertion_enable_bits = 32'h0, rnd = 32'h8EE8;
   logic [127:0] exp_regs = 128'h0;
   logic [127:0] exp_stage = 128'h0, h0 = 128'h0, h1 = 128'h0, h2 = 128'h0;
   logic         bp_chk = 1'b0, e_sig, e_ser;
   int           bp_pos = -1, bp_p;
   wire logic    rx_backplane_clock, rx_multiframe_sync, rx_serial_data_in;
   wire logic    rx_latched_status_four, interrupt_out_n, freeze_indicator_out;
   wire logic    rx_signaling_stream_out, rx_serial_data_out;
   wire logic [31:0]  rx_signaling_change_flags;
   wire logic [127:0] rx_signaling_regs;
   int           n_errors = 0, cmp_count = 0;
   // short hold counts keep the freeze scenarios brief
   rsu_rx_signaling_unit #(.HOLD_ESF_CYC(18'h14), .HOLD_D4_CYC(18'h0C),
      .HOLD_E1_CYC(18'h10)) i_rsu_rx_signaling_unit (.*);
   rsu_backplane_model i_rsu_backplane_model (.rate_2048(backplane_rate_2048),
      .bp_clk(rx_backplane_clock), .mf_sync(rx_multiframe_sync),
      .ser_data(rx_serial_data_in));
   always #25 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int hold_cyc(input logic [1:0] m);
      return (m == 2'h1) ? 12 : (m == 2'h2) ? 16 : 20;
   endfunction
   // expected stream bit at position p of a 193-bit frame, MSB first
   function automatic logic exp_stream(input int p, input logic [1:0] m,
                                       input logic [127:0] w);
      logic [3:0] a;
      logic [7:0] b;
      if (p == 0)
         return 1'b0;
      a = force_ones_select_bits[(p - 1) / 8] ? 4'hF :
          w[((p - 1) / 8) * 4 +: 4];
      b = (m == 2'h1) ? {4'h0, a[3:2], a[3:2]} : {4'h0, a};
      return b[7 - (p - 1) % 8];
   endfunction
   // expected serial bit: only the LSB of frames 5, 11, 17, 23 may change
   function automatic logic exp_serial(input int p, input int fr,
                                       input logic [127:0] w, input logic d);
      int c;
      c = (p - 1) / 8;
      if (p == 0 || (p - 1) % 8 != 7 || fr % 6 != 5)
         return d;
      if (force_ones_select_bits[c])
         return 1'b1;
      if (elastic_store_enable && reinsertion_enable_bits[c])
         return w[c * 4 + 3 - fr / 6];
      return d;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input string nm, input logic [127:0] e,
                      input logic [127:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic send(input logic [4:0] ch, input logic [3:0] v);
      exp_stage[ch*4 +: 4] = v;
      @(posedge clk_sys);
      sig_valid <= 1'b1;
      sig_channel <= ch;
      sig_abcd <= v;
      @(posedge clk_sys);
      sig_valid <= 1'b0;
   endtask
   task automatic mfb();
      @(posedge clk_sys);
      multiframe_boundary <= 1'b1;
      @(posedge clk_sys);
      multiframe_boundary <= 1'b0;
      // a frozen boundary stores nothing in the signaling buffer
      if (!freeze_force) begin
         h2 = h1;
         h1 = h0;
         h0 = exp_stage;
      end
      cyc(3);
   endtask
   // bit count from the sync pin; the outputs settle well before the fall
   always @(negedge rx_backplane_clock) begin
      bp_pos = rx_multiframe_sync ? 0 : bp_pos + 1;
      bp_p = bp_pos % 193;
      e_sig = exp_stream(bp_p, mode_sel, h2);
      e_ser = exp_serial(bp_p, bp_pos / 193, h2, rx_serial_data_in);
      if (bp_chk) begin
         chk("stream", e_sig, rx_signaling_stream_out);
         chk("serial", e_ser, rx_serial_data_out);
      end
   end
   task automatic clr();
      @(posedge clk_sys);
      change_flags_clear <= 32'hFFFFFFFF;
      latched_status_clear <= 1'b1;
      @(posedge clk_sys);
      change_flags_clear <= 32'h0;
      latched_status_clear <= 1'b0;
      cyc(2);
   endtask
   task automatic summarize();
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      logic [4:0] ch;
      logic [3:0] v;
      cyc(8);
      rst_b <= 1'b1;
      cyc(3);
      change_state_enable_bits <= rnd | 32'h1;
      reinsertion_enable_bits <= ~rnd;
      force_ones_select_bits <= rnd[23:0];
      backplane_rate_2048 <= rnd[0];
      rx_interrupt_mask_four <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         ch = (i == 0) ? 5'h0 : (i == 1) ? 5'h17 : rnd[4:0] % 5'h18;
         v = exp_regs[ch*4 +: 4] ^ (rnd[11:8] | 4'h1);
         send(ch, v);
         chk("regs early", exp_regs, rx_signaling_regs);
         mfb();
         exp_regs[ch*4 +: 4] = v;
         chk("regs", exp_regs, rx_signaling_regs);
         chk("flags", {96'h0, 32'h1 << ch}, rx_signaling_change_flags);
         chk("latched", change_state_enable_bits[ch], rx_latched_status_four);
         chk("irq", !change_state_enable_bits[ch], interrupt_out_n);
         clr();
         chk("irq cleared", 1'b1, interrupt_out_n);
      end
      {out_of_frame, loss_of_frame} <= 2'h3;
      send(5'h5, ~exp_regs[23:20]);
      mfb();
      chk("regs in loss", exp_regs, rx_signaling_regs);
      chk("flags in loss", 128'h0, rx_signaling_change_flags);
      {out_of_frame, loss_of_frame} <= 2'h0;
      mfb();
      exp_regs[23:20] = ~exp_regs[23:20];
      chk("regs after loss", exp_regs, rx_signaling_regs);
      clr();
      integration_enable <= 1'b1;
      v = ~exp_regs[3:0];
      send(5'h0, v);
      repeat (2) begin
         mfb();
         chk("regs integrating", exp_regs, rx_signaling_regs);
      end
      mfb();
      exp_regs[3:0] = v;
      chk("regs integrated", exp_regs, rx_signaling_regs);
      chk("flags integrated", 128'h1, rx_signaling_change_flags);
      integration_enable <= 1'b0;
      freeze_force <= 1'b1;
      cyc(3);
      chk("forced freeze", 1'b1, freeze_indicator_out);
      freeze_force <= 1'b0;
      cyc(3);
      chk("freeze off", 1'b0, freeze_indicator_out);
      freeze_enable <= 1'b1;
      // three fault kinds, each paired with a framing mode and its own hold time
      for (int k = 0; k < 3; k++) begin
         mode_sel <= k[1:0];
         {loss_of_frame, carrier_loss, alignment_change} <= 3'h1 << k;
         cyc(3);
         chk("fault freeze", 1'b1, freeze_indicator_out);
         {loss_of_frame, carrier_loss, alignment_change} <= 3'h0;
         cyc(hold_cyc(k[1:0]) - 4);
         chk("freeze hold", 1'b1, freeze_indicator_out);
         cyc(8);
         chk("freeze end", 1'b0, freeze_indicator_out);
      end
      freeze_enable <= 1'b0;
      mode_sel <= 2'h0;
      // refill the buffer; the third boundary falls in a forced freeze
      for (int i = 0; i < 5; i++) begin
         rnd = lfsr(rnd);
         freeze_force <= (i == 2);
         send(rnd[4:0] % 5'h18, rnd[15:12]);
         mfb();
      end
      freeze_force <= 1'b0;
      cyc(20);
      // ESF through robbed frame 5, then D4 repeats A and B
      bp_chk = 1'b1;
      wait (bp_pos > 1170);
      bp_chk = 1'b0;
      mode_sel <= 2'h1;
      cyc(20);
      bp_chk = 1'b1;
      wait (bp_pos > 1400);
      bp_chk = 1'b0;
      summarize();
   end
   initial begin
      cyc(15000);
      n_errors++;
      summarize();
   end
endmodule
`default_nettype wire
